/* File: core/watchdog_status_top.sv */
// Watchdog status register, unlock sequencer and reload byte holders
// Assumes an AXI4-Lite master with one write and one read outstanding
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
module watchdog_status_top
	import wdt_status_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        por_event,
	input  wire logic        ext_reset_event,
	input  wire logic        timeout_event,
	input  wire logic        in_stop_mode,
	input  wire logic        debugger_reset,
	input  wire logic        debug_pin_reset,
	input  wire logic        pin_recovery,
	input  wire logic [23:0] current_count,
	output logic [23:0]      reload_value,
	output logic             stop_mode_disable,
	output logic             reload_unlocked
);
	////////////////////////////////////////////////////////////////////
	// Decode helper
	// Word match of a byte address against a register address
	function automatic logic hits(input logic [11:0] a,
		input logic [11:0] r);
		hits = (a[11:ADDR_LSB] == r[11:ADDR_LSB]);
	endfunction

	// Byte lane of a register address inside its word
	function automatic logic [7:0] lane(input logic [31:0] d,
		input logic [11:0] r);
		lane = d[8*r[1:0] +: 8];
	endfunction

	////////////////////////////////////////////////////////////////////
	// Write channel state
	logic        aw_have_reg, aw_have_next;   // Address captured
	logic        w_have_reg, w_have_next;     // Data captured
	logic [11:0] waddr_reg, waddr_next;       // Captured address
	logic [31:0] wdata_reg, wdata_next;       // Captured data
	logic [3:0]  wstrb_reg, wstrb_next;       // Captured strobes
	logic        bvalid_reg, bvalid_next;     // Write answer
	logic [1:0]  bresp_reg, bresp_next;       // Write response
	logic        awready_reg, awready_next;   // Address ready
	logic        wready_reg, wready_next;     // Data ready
	logic        do_write;                    // Write commits now

	// Write channel next values; address and data in either order
	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		waddr_next   = waddr_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		do_write     = 1'b0;
		if (s_axi_awvalid && awready_reg) begin
			aw_have_next = 1'b1;
			waddr_next   = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_have_next = 1'b1;
			wdata_next  = s_axi_wdata;
			wstrb_next  = s_axi_wstrb;
		end
		if (aw_have_reg && w_have_reg && !bvalid_reg) begin
			do_write     = 1'b1;
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			// Unmapped word answers with slave error
			bresp_next   = hits(waddr_reg, STATUS_ADDR) ?
				RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_have_next && !bvalid_next;
		wready_next  = !w_have_next && !bvalid_next;
	end

	// Write channel registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			waddr_reg   <= 12'h000;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			waddr_reg   <= waddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Byte write decode: the four registers share one word
	logic       wr_status, wr_up, wr_hi, wr_lo; // Lane writes
	logic       wr_any;                         // Any register write
	logic [7:0] by_status, by_up, by_hi, by_lo; // Written bytes

	// Splits a committed word write into per-byte register writes
	always_comb begin
		wr_status = do_write && hits(waddr_reg, STATUS_ADDR) &&
			wstrb_reg[STATUS_ADDR[1:0]];
		wr_up     = do_write && hits(waddr_reg, RELOAD_UP_ADDR) &&
			wstrb_reg[RELOAD_UP_ADDR[1:0]];
		wr_hi     = do_write && hits(waddr_reg, RELOAD_HI_ADDR) &&
			wstrb_reg[RELOAD_HI_ADDR[1:0]];
		wr_lo     = do_write && hits(waddr_reg, RELOAD_LO_ADDR) &&
			wstrb_reg[RELOAD_LO_ADDR[1:0]];
		wr_any    = wr_status | wr_up | wr_hi | wr_lo;
		by_status = lane(wdata_reg, STATUS_ADDR);
		by_up     = lane(wdata_reg, RELOAD_UP_ADDR);
		by_hi     = lane(wdata_reg, RELOAD_HI_ADDR);
		by_lo     = lane(wdata_reg, RELOAD_LO_ADDR);
	end

	////////////////////////////////////////////////////////////////////
	// Lock state machine, config bit and reload bytes
	lock_state_t lock_reg, lock_next;   // Unlock progress
	logic        cfg_reg, cfg_next;     // Stop-mode disable
	logic [7:0]  up_reg, up_next;       // Reload upper byte
	logic [7:0]  hi_reg, hi_next;       // Reload high byte
	logic [7:0]  lo_reg, lo_next;       // Reload low byte

	// Only one byte lane steers the machine; status lane takes priority
	always_comb begin
		lock_next = lock_reg;
		cfg_next  = cfg_reg;
		up_next   = up_reg;
		hi_next   = hi_reg;
		lo_next   = lo_reg;
		if (wr_any) begin
			lock_next = LOCK_IDLE;
			unique case (lock_reg)
				LOCK_IDLE: begin
					if (wr_status && by_status == UNLOCK_FIRST)
						lock_next = LOCK_ONE;
				end
				LOCK_ONE: begin
					if (wr_status && by_status == UNLOCK_SECOND)
						lock_next = LOCK_UP;
				end
				LOCK_UP: begin
					if (wr_status && by_status == CFG_STOP_OFF) begin
						cfg_next = 1'b1;
					end else if (wr_status && by_status == CFG_STOP_ON) begin
						cfg_next = 1'b0;
					end else if (wr_up && !wr_status) begin
						up_next   = by_up;
						lock_next = LOCK_HI;
					end
				end
				LOCK_HI: begin
					if (wr_hi && !wr_status && !wr_up) begin
						hi_next   = by_hi;
						lock_next = LOCK_LO;
					end
				end
				LOCK_LO: begin
					if (wr_lo && !wr_status && !wr_up && !wr_hi)
						lo_next = by_lo;
				end
				default: lock_next = LOCK_IDLE;
			endcase
		end
	end

	// Lock, config and reload registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lock_reg <= LOCK_IDLE;
			cfg_reg  <= CFG_RESET;
			up_reg   <= RELOAD_RESET;
			hi_reg   <= RELOAD_RESET;
			lo_reg   <= RELOAD_RESET;
		end else begin
			lock_reg <= lock_next;
			cfg_reg  <= cfg_next;
			up_reg   <= up_next;
			hi_reg   <= hi_next;
			lo_reg   <= lo_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel
	logic        arready_reg, arready_next; // Address ready
	logic        rvalid_reg, rvalid_next;   // Read answer
	logic [31:0] rdata_reg, rdata_next;     // Read data
	logic [1:0]  rresp_reg, rresp_next;     // Read response
	logic        read_clear;                // Status read this cycle
	logic [3:0]  flags;                     // Cause flags

	// Takes a read address and answers on the next cycle
	always_comb begin
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		read_clear   = 1'b0;
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next  = 1'b1;
			if (hits(s_axi_araddr, STATUS_ADDR)) begin
				// Status at lane 0, count bytes in lanes 1 to 3
				rdata_next = {current_count[7:0], current_count[15:8],
					current_count[23:16], flags, 3'b000, cfg_reg};
				rresp_next = RESP_OKAY;
				read_clear = 1'b1;
			end else begin
				rdata_next = 32'h0000_0000;
				rresp_next = RESP_SLVERR;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next  = 1'b0;
		end
		// Address channel stays shut while an answer stands
		arready_next = !rvalid_next;
	end

	// Read channel registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Cause flags
	cause_flags u_flags (
		.clock           (clock),
		.resetn          (resetn),
		.por_event       (por_event),
		.ext_reset_event (ext_reset_event),
		.timeout_event   (timeout_event),
		.in_stop_mode    (in_stop_mode),
		.debugger_reset  (debugger_reset),
		.debug_pin_reset (debug_pin_reset),
		.pin_recovery    (pin_recovery),
		.read_clear      (read_clear),
		.flags           (flags)
	);

	// Outputs registered
	always_ff @(posedge clock) begin
		if (!resetn) begin
			reload_value      <= {RELOAD_RESET, RELOAD_RESET, RELOAD_RESET};
			stop_mode_disable <= CFG_RESET;
			reload_unlocked   <= 1'b0;
		end else begin
			reload_value      <= {up_next, hi_next, lo_next};
			stop_mode_disable <= cfg_next;
			reload_unlocked   <= (lock_next == LOCK_UP) ||
				(lock_next == LOCK_HI) || (lock_next == LOCK_LO);
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence first_byte_s;
		wr_status && by_status == UNLOCK_FIRST && lock_reg == LOCK_IDLE;
	endsequence
	sequence second_byte_s;
		wr_status && by_status == UNLOCK_SECOND && lock_reg == LOCK_ONE;
	endsequence
	// First unlock byte arms the machine
	unlock_first_a: assert property (@(posedge clock) disable iff (!resetn)
		first_byte_s |=> lock_reg == LOCK_ONE)
		else $error("first unlock byte not taken");
	// Unlock pair opens the reload bytes
	unlock_pair_a: assert property (@(posedge clock) disable iff (!resetn)
		second_byte_s |=> lock_reg == LOCK_UP && reload_unlocked)
		else $error("unlock pair did not open");
	// Unlock writes leave config bit alone
	unlock_keep_a: assert property (@(posedge clock) disable iff (!resetn)
		(wr_status && lock_reg != LOCK_UP) |=> $stable(cfg_reg))
		else $error("unlock write changed status");
	// Stray write in idle state keeps it locked
	stray_write_a: assert property (@(posedge clock) disable iff (!resetn)
		(wr_any && !wr_status && lock_reg == LOCK_IDLE) |=>
		lock_reg == LOCK_IDLE)
		else $error("stray write did not relock");
	// Status read clears flags unless event
	read_clear_a: assert property (@(posedge clock) disable iff (!resetn)
		(read_clear && !por_event && !timeout_event && !pin_recovery &&
		!ext_reset_event && !debugger_reset && !debug_pin_reset) |=>
		flags == 4'h0 && $stable(cfg_reg))
		else $error("status read did not clear");
endmodule

/* File: core/wdt_status_pkg.sv */
// Package for the watchdog status and unlock block
// Assumes AXI4-Lite with 32-bit data and one register word per address
package wdt_status_pkg;
	// Byte addresses of the register window
	localparam logic [11:0] STATUS_ADDR     = 12'hFF0;
	localparam logic [11:0] RELOAD_UP_ADDR  = 12'hFF1;
	localparam logic [11:0] RELOAD_HI_ADDR  = 12'hFF2;
	localparam logic [11:0] RELOAD_LO_ADDR  = 12'hFF3;
	// Lowest word-select bit (byte address is four times the word index)
	localparam int          ADDR_LSB        = 2;
	// Field positions of the status register
	localparam int          POR_BIT         = 7;
	localparam int          STOP_BIT        = 6;
	localparam int          TIMEOUT_BIT     = 5;
	localparam int          EXTRST_BIT      = 4;
	localparam int          CFG_BIT         = 0;
	// Unlock and configuration byte codes
	localparam logic [7:0]  UNLOCK_FIRST    = 8'h55;
	localparam logic [7:0]  UNLOCK_SECOND   = 8'hAA;
	localparam logic [7:0]  CFG_STOP_OFF    = 8'h81;
	localparam logic [7:0]  CFG_STOP_ON     = 8'h00;
	// Values after reset
	localparam logic [7:0]  RELOAD_RESET    = 8'hFF;
	localparam logic        CFG_RESET       = 1'b0;
	// AXI response codes
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	// Lock state machine
	typedef enum logic [2:0] {
		LOCK_IDLE  = 3'b000,
		LOCK_ONE   = 3'b001,
		LOCK_UP    = 3'b010,
		LOCK_HI    = 3'b011,
		LOCK_LO    = 3'b100
	} lock_state_t;
endpackage

/* File: core/cause_flags.sv */
// Cause flag register: power-on, stop, time-out and external reset flags
// Assumes event strobes are one-cycle pulses on the system clock
`timescale 1ns/100ps
module cause_flags
	import wdt_status_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       por_event,
	input  wire logic       ext_reset_event,
	input  wire logic       timeout_event,
	input  wire logic       in_stop_mode,
	input  wire logic       debugger_reset,
	input  wire logic       debug_pin_reset,
	input  wire logic       pin_recovery,
	input  wire logic       read_clear,
	output logic      [3:0] flags
);
	logic [3:0] flags_reg;  // {por, stop, timeout, ext}
	logic [3:0] flags_next; // Next flag value
	logic       por_like;   // Any event that reports power-on pattern

	// Next-state logic; events override the read clear
	always_comb begin
		flags_next = flags_reg;
		por_like   = por_event | debugger_reset | debug_pin_reset;
		if (read_clear) begin
			flags_next = 4'h0;
		end
		if (por_like) begin
			flags_next = 4'h8;
		end else if (timeout_event && in_stop_mode) begin
			flags_next = 4'h6;
		end else if (timeout_event) begin
			flags_next = 4'h2;
		end else if (pin_recovery) begin
			flags_next = 4'h4;
		end else if (ext_reset_event) begin
			flags_next = 4'h1;
		end
	end

	// Registers the flags; a synchronous reset behaves as power-on
	always_ff @(posedge clock) begin
		if (!resetn) begin
			flags_reg <= 4'h8;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign flags = flags_reg;

	// Event beats a read in the same cycle
	event_wins_a: assert property (@(posedge clock) disable iff (!resetn)
		(read_clear && (por_like || timeout_event || pin_recovery ||
		ext_reset_event)) |=> flags_reg != 4'h0)
		else $error("event flag lost to read");
	// Pin recovery leaves only stop flag
	pin_rec_a: assert property (@(posedge clock) disable iff (!resetn)
		(pin_recovery && !timeout_event && !por_like) |=>
		flags_reg == 4'h4)
		else $error("pin recovery pattern wrong");
	// Stop time-out sets stop and time-out
	stop_tmo_a: assert property (@(posedge clock) disable iff (!resetn)
		(timeout_event && in_stop_mode && !por_like) |=>
		flags_reg == 4'h6)
		else $error("stop timeout pattern wrong");
	// Debugger reset looks like power-on
	dbg_rst_a: assert property (@(posedge clock) disable iff (!resetn)
		(debugger_reset || debug_pin_reset) |=> flags_reg == 4'h8)
		else $error("debug reset pattern wrong");
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the watchdog status and unlock block
// Assumes one status word at STATUS_ADDR and a 25 MHz system clock
`timescale 1ns/100ps
module testbench
	import wdt_status_pkg::*;
;
	////////////////////////////////////////////////////////////////////////
	// Event codes: {por, ext, timeout, in stop, debugger, debug pin, pin}
	localparam logic [6:0] E_POR  = 7'h40;
	localparam logic [6:0] E_EXT  = 7'h20;
	localparam logic [6:0] E_TO   = 7'h10;
	localparam logic [6:0] E_STOP = 7'h08;
	localparam logic [6:0] E_DBG  = 7'h04;
	localparam logic [6:0] E_DPIN = 7'h02;
	localparam logic [6:0] E_PIN  = 7'h01;
	// One row: first event, optional second event, expected flag byte
	typedef struct packed {
		logic [6:0] first;
		logic [6:0] second;
		logic [7:0] status;
	} row_t;
	localparam row_t ROWS [14] = '{
		'{E_POR, 7'h00, 8'h80}, '{E_EXT, 7'h00, 8'h10},
		'{E_TO, 7'h00, 8'h20}, '{E_DBG, 7'h00, 8'h80},
		'{E_DPIN, 7'h00, 8'h80}, '{E_PIN, 7'h00, 8'h40},
		'{E_TO | E_STOP, 7'h00, 8'h60}, '{E_POR, E_TO, 8'h20},
		'{E_POR, E_PIN, 8'h40}, '{E_PIN, E_POR, 8'h80},
		'{E_PIN, E_TO, 8'h20}, '{E_TO, E_PIN, 8'h40},
		'{E_EXT, E_PIN, 8'h40}, '{E_EXT, E_POR, 8'h80}};
	////////////////////////////////////////////////////////////////////////
	// Signals of the design
	logic        clock, resetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        por_event, ext_reset_event, timeout_event, in_stop_mode;
	logic        debugger_reset, debug_pin_reset, pin_recovery;
	logic [23:0] current_count, reload_value;
	logic        stop_mode_disable, reload_unlocked;
	int          n_fail    = 0;
	int          cmp_count = 0;

	watchdog_status_top u_dut (.clock(clock), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .por_event(por_event),
		.ext_reset_event(ext_reset_event), .timeout_event(timeout_event),
		.in_stop_mode(in_stop_mode), .debugger_reset(debugger_reset),
		.debug_pin_reset(debug_pin_reset), .pin_recovery(pin_recovery),
		.current_count(current_count), .reload_value(reload_value),
		.stop_mode_disable(stop_mode_disable),
		.reload_unlocked(reload_unlocked));

	// 40 ns system clock
	always #20 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	// Verdict and compares
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Drivers: events are one-cycle pulses, bus requests held until taken
	task automatic drive_ev(input logic [6:0] e);
		por_event       <= e[6];
		ext_reset_event <= e[5];
		timeout_event   <= e[4];
		in_stop_mode    <= e[3];
		debugger_reset  <= e[2];
		debug_pin_reset <= e[1];
		pin_recovery    <= e[0];
	endtask

	task automatic pulse(input logic [6:0] e);
		drive_ev(e);
		@(posedge clock);
		drive_ev(7'h00);
		@(posedge clock);
	endtask

	task automatic hold_reset();
		repeat (8) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
	endtask

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge clock);
			if (!aw_done && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w_done = 1'b1;
			end
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				break;
			end
		end
	endtask

	// Read, optionally pulsing events in the cycle the address is offered
	task automatic axi_read(input logic [11:0] a, input logic [6:0] e,
			output logic [31:0] d, output logic [1:0] r);
		logic ar_done;
		ar_done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		if (e !== 7'h00) drive_ev(e);
		forever begin
			@(posedge clock);
			if (!ar_done && e !== 7'h00) drive_ev(7'h00);
			if (!ar_done && s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
				ar_done = 1'b1;
			end
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				break;
			end
		end
	endtask

	task automatic check_status(input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(STATUS_ADDR, 7'h00, d, r);
		chk_val({24'h000000, d[7:0]}, {24'h000000, e});
		chk_resp(r, RESP_OKAY);
	endtask

	// Byte to one lane of the status word; other lanes zero and unstrobed
	task automatic wr_lane(input int idx, input logic [7:0] b);
		logic [1:0] r;
		axi_write(STATUS_ADDR, {24'h000000, b} << (8 * idx),
			4'h1 << idx, r);
	endtask

	task automatic unlock();
		wr_lane(0, UNLOCK_FIRST);
		wr_lane(0, UNLOCK_SECOND);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog against a hung handshake
	initial begin
		repeat (6000) @(posedge clock);
		n_fail++;
		print_verdict();
	end

	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		clock = 1'b0;
		resetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		{por_event, ext_reset_event, timeout_event, in_stop_mode} = '0;
		{debugger_reset, debug_pin_reset, pin_recovery} = '0;
		current_count = 24'hABCDEF;
		hold_reset();
		chk_val({8'h00, reload_value}, 32'h00FFFFFF);
		chk_val({31'h0, reload_unlocked}, 32'h0);
		chk_val({31'h0, stop_mode_disable}, 32'h0);
		check_status(8'h80);
		check_status(8'h00);
		// Event table: each row ends with a clearing read
		foreach (ROWS[i]) begin
			pulse(ROWS[i].first);
			if (ROWS[i].second !== 7'h00) pulse(ROWS[i].second);
			check_status(ROWS[i].status);
		end
		// Count lanes beside the status byte
		axi_read(STATUS_ADDR, 7'h00, d, r);
		chk_val(d, 32'hEFCDAB00);
		// Lone config byte without unlock is ignored
		wr_lane(0, CFG_STOP_OFF);
		chk_val({31'h0, stop_mode_disable}, 32'h0);
		// Stop configuration through the three-byte sequence
		pulse(E_EXT);
		unlock();
		chk_val({31'h0, reload_unlocked}, 32'h1);
		wr_lane(0, CFG_STOP_OFF);
		chk_val({31'h0, stop_mode_disable}, 32'h1);
		check_status(8'h11);
		check_status(8'h01);
		unlock();
		wr_lane(0, CFG_STOP_ON);
		chk_val({31'h0, stop_mode_disable}, 32'h0);
		check_status(8'h00);
		// Reload bytes in order, then relocked
		unlock();
		wr_lane(1, 8'h12);
		wr_lane(2, 8'h34);
		wr_lane(3, 8'h56);
		chk_val({8'h00, reload_value}, 32'h00123456);
		chk_val({31'h0, reload_unlocked}, 32'h0);
		wr_lane(1, 8'h99);
		// Broken sequences leave the reload untouched
		wr_lane(0, UNLOCK_FIRST);
		wr_lane(0, 8'h12);
		wr_lane(0, UNLOCK_SECOND);
		wr_lane(1, 8'h77);
		unlock();
		wr_lane(0, 8'h33);
		wr_lane(1, 8'h77);
		chk_val({8'h00, reload_value}, 32'h00123456);
		// Event in the same cycle as the clearing read
		axi_read(STATUS_ADDR, E_POR, d, r);
		chk_val({24'h000000, d[7:0]}, 32'h00000000);
		check_status(8'h80);
		axi_read(STATUS_ADDR, E_TO, d, r);
		chk_val({24'h000000, d[7:0]}, 32'h00000000);
		check_status(8'h20);
		// Unmapped word
		axi_read(12'h100, 7'h00, d, r);
		chk_resp(r, RESP_SLVERR);
		chk_val(d, 32'h00000000);
		axi_write(12'h100, 32'h00000000, 4'hF, r);
		chk_resp(r, RESP_SLVERR);
		// Second reset in mid-run
		unlock();
		wr_lane(0, CFG_STOP_OFF);
		pulse(E_EXT);
		resetn <= 1'b0;
		hold_reset();
		chk_val({31'h0, stop_mode_disable}, 32'h0);
		chk_val({8'h00, reload_value}, 32'h00FFFFFF);
		check_status(8'h80);
		print_verdict();
	end
endmodule
